// >>> src/socket_detect_power_switch_ctrl.sv
// Socket detect, power state machines, switch encoder and serial link
//
// Operation
// - A low level on sdmmc_detect_n means a card sits in the SD/MMC socket.
// - A low level on flash2_detect_n means a card sits in the second flash socket.
// - An insertion is accepted only after the detect input has stayed low for about 50 ms.
// - A removal is accepted at once, with no debounce.
// - The SD/MMC socket has a three-state machine: empty/off, present/off, present/on.
// - The second socket has its own machine with the same three states.
// - The eleven switch control bits go out over a three-pin serial link.
// - switch_type_select picks the voltage flag only; the word is sent unchanged for both types; after reset the first switch type is used.
// - First type programming code: 00x 0 V, 010 3.3 V, 011 5 V, 10x/110 Hi-Z, 111 1.8 V.
// - Supply code on D3,D2 (B on D6,D7): 00 0 V, 01 3.3 V, 10 5 V, 11 0 V.
// - Second type programming code: 00x 0 V, 010 3.3 V, 011 5 V, 10x 12 V, 11x Hi-Z.
// - D8 is an active-low shutdown that floats every socket supply when 0.
// - A free-running 16 kHz tick paces power-up, power-down and the serial link.
// - The status-change pin pulls up for a 16-bit card and down for a CardBus card.
// - A 1.8 V core CardBus card sets the 3.3 V flag when select is 0, else the X.X V flag.
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
module socket_detect_power_switch_ctrl
	import sock_pwr_pkg::*;
#(
	parameter int unsigned DEBOUNCE_CNT = DEBOUNCE_CYCLES,
	parameter int unsigned OSC_HALF     = OSC_HALF_CYCLES
)(
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	input  wire logic        sdmmc_detect_n_i,
	input  wire logic        flash2_detect_n_i,
	input  wire logic [7:0]  s_axi_awaddr_i,
	input  wire logic        s_axi_awvalid_i,
	output logic             s_axi_awready_o,
	input  wire logic [31:0] s_axi_wdata_i,
	input  wire logic [3:0]  s_axi_wstrb_i,
	input  wire logic        s_axi_wvalid_i,
	output logic             s_axi_wready_o,
	output logic [1:0]       s_axi_bresp_o,
	output logic             s_axi_bvalid_o,
	input  wire logic        s_axi_bready_i,
	input  wire logic [7:0]  s_axi_araddr_i,
	input  wire logic        s_axi_arvalid_i,
	output logic             s_axi_arready_o,
	output logic [31:0]      s_axi_rdata_o,
	output logic [1:0]       s_axi_rresp_o,
	output logic             s_axi_rvalid_o,
	input  wire logic        s_axi_rready_i,
	output logic             sw_clock_o,
	output logic             sw_data_o,
	output logic             sw_latch_o,
	output logic             status_change_pullup_o,
	output logic             status_change_pulldown_o,
	output logic             low_volt_card_flag_o,
	output logic             xx_volt_card_flag_o,
	output logic             irq_o
);
	// Tick counter is 16 bits wide, so a full tick period must fit in it
	if (DEBOUNCE_CNT < 1 || OSC_HALF < 2 || OSC_HALF > 32768)
	begin : g_bad_param
		$error("Counts out of range");
	end

	////////////////////////////////////////////////////////////////////////
	// Reset release and input synchronisers
	logic       rst_s1_reg;
	logic       rst_n;
	logic [1:0] det_s1_reg;
	logic [1:0] det_s2_reg;

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			rst_s1_reg <= 1'b0;
			rst_n      <= 1'b0;
		end
		else
		begin
			rst_s1_reg <= 1'b1;
			rst_n      <= rst_s1_reg;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			det_s1_reg <= 2'b11;
			det_s2_reg <= 2'b11;
		end
		else
		begin
			det_s1_reg <= {flash2_detect_n_i, sdmmc_detect_n_i};
			det_s2_reg <= det_s1_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Internal 16 kHz tick, free running
	logic [15:0] osc_cnt_reg;
	logic        osc_tick;

	assign osc_tick = (osc_cnt_reg == 16'(OSC_HALF * 2 - 1));

	always_ff @(posedge clk_i or negedge rst_n)
	begin
		if (!rst_n)
			osc_cnt_reg <= 16'h0000;
		else if (osc_tick)
			osc_cnt_reg <= 16'h0000;
		else
			osc_cnt_reg <= osc_cnt_reg + 16'h0001;
	end

	////////////////////////////////////////////////////////////////////////
	// Registers
	logic [31:0]       ctrl_reg;
	logic [31:0]       sock_a_reg;
	logic [31:0]       sock_b_reg;
	logic [IRQ_W-1:0]  irq_stat_reg;
	logic [IRQ_W-1:0]  irq_en_reg;
	logic [1:0]        present;
	sock_state_t       state_reg [2];
	logic [IRQ_W-1:0]  irq_set;
	logic [IRQ_W-1:0]  irq_clr;
	logic              swsel;

	assign swsel = ctrl_reg[CTRL_SWSEL_BIT];

	////////////////////////////////////////////////////////////////////////
	// Debounce and per-socket state machines
	logic [31:0] deb_cnt_reg [2];
	logic [1:0]  ins_evt;
	logic [1:0]  rem_evt;

	for (genvar s = 0; s < 2; s++)
	begin : g_sock
		logic pwr_req;
		assign pwr_req = ctrl_reg[s == 0 ? CTRL_PWR_A_BIT : CTRL_PWR_B_BIT];
		// Low level means inserted; removal bypasses the filter
		assign rem_evt[s] = present[s] && det_s2_reg[s];
		assign ins_evt[s] = !present[s] && deb_cnt_reg[s] == DEBOUNCE_CNT - 1;

		always_ff @(posedge clk_i or negedge rst_n)
		begin
			if (!rst_n)
				deb_cnt_reg[s] <= 32'h0000_0000;
			else if (det_s2_reg[s] || present[s])
				deb_cnt_reg[s] <= 32'h0000_0000;
			else
				deb_cnt_reg[s] <= deb_cnt_reg[s] + 32'h0000_0001;
		end

		always_ff @(posedge clk_i or negedge rst_n)
		begin
			if (!rst_n)
				state_reg[s] <= SOCK_EMPTY;
			else
			begin
				case (state_reg[s])
					SOCK_EMPTY:
						if (ins_evt[s])
							state_reg[s] <= SOCK_PRESENT_OFF;
					SOCK_PRESENT_OFF:
						if (rem_evt[s])
							state_reg[s] <= SOCK_EMPTY;
						else if (pwr_req && osc_tick)
							state_reg[s] <= SOCK_PRESENT_ON;
					SOCK_PRESENT_ON:
						if (rem_evt[s])
							state_reg[s] <= SOCK_EMPTY;
						else if (!pwr_req && osc_tick)
							state_reg[s] <= SOCK_PRESENT_OFF;
					default:
						state_reg[s] <= SOCK_EMPTY;
				endcase
			end
		end
		assign present[s] = state_reg[s] != SOCK_EMPTY;
	end

	assign irq_set = {rem_evt[1], ins_evt[1], rem_evt[0], ins_evt[0]};

	////////////////////////////////////////////////////////////////////////
	// AXI4-Lite slave
	logic        aw_held_reg;
	logic        w_held_reg;
	logic [7:0]  awaddr_reg;
	logic [31:0] wdata_reg;
	logic [3:0]  wstrb_reg;
	logic        do_write;
	logic [31:0] rd_val;
	logic        rd_ok;

	assign do_write = aw_held_reg && w_held_reg && !s_axi_bvalid_o;

	always_ff @(posedge clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			aw_held_reg     <= 1'b0;
			w_held_reg      <= 1'b0;
			awaddr_reg      <= 8'h00;
			wdata_reg       <= 32'h0000_0000;
			wstrb_reg       <= 4'h0;
			s_axi_awready_o <= 1'b0;
			s_axi_wready_o  <= 1'b0;
			s_axi_bvalid_o  <= 1'b0;
			s_axi_bresp_o   <= RESP_OKAY;
		end
		else
		begin
			s_axi_awready_o <= !aw_held_reg && !s_axi_awready_o;
			s_axi_wready_o  <= !w_held_reg && !s_axi_wready_o;
			if (s_axi_awvalid_i && s_axi_awready_o)
			begin
				aw_held_reg     <= 1'b1;
				awaddr_reg      <= s_axi_awaddr_i;
				s_axi_awready_o <= 1'b0;
			end
			if (s_axi_wvalid_i && s_axi_wready_o)
			begin
				w_held_reg     <= 1'b1;
				wdata_reg      <= s_axi_wdata_i;
				wstrb_reg      <= s_axi_wstrb_i;
				s_axi_wready_o <= 1'b0;
			end
			if (do_write)
			begin
				s_axi_bvalid_o <= 1'b1;
				s_axi_bresp_o  <= (awaddr_reg == CTRL_OFF || awaddr_reg == IRQ_EN_OFF ||
					awaddr_reg == IRQ_CLR_OFF || awaddr_reg == SOCK_A_OFF ||
					awaddr_reg == SOCK_B_OFF) ? RESP_OKAY : RESP_SLVERR;
			end
			if (s_axi_bvalid_o && s_axi_bready_i)
			begin
				s_axi_bvalid_o <= 1'b0;
				aw_held_reg    <= 1'b0;
				w_held_reg     <= 1'b0;
			end
		end
	end

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (be[i])
				r[i*8 +: 8] = nw[i*8 +: 8];
		return r;
	endfunction

	always_ff @(posedge clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ctrl_reg   <= CTRL_RESET;
			sock_a_reg <= SOCK_RESET;
			sock_b_reg <= SOCK_RESET;
			irq_en_reg <= '0;
		end
		else if (do_write)
		begin
			if (awaddr_reg == CTRL_OFF)
				ctrl_reg <= merge(ctrl_reg, wdata_reg, wstrb_reg);
			if (awaddr_reg == SOCK_A_OFF)
				sock_a_reg <= merge(sock_a_reg, wdata_reg, wstrb_reg);
			if (awaddr_reg == SOCK_B_OFF)
				sock_b_reg <= merge(sock_b_reg, wdata_reg, wstrb_reg);
			if (awaddr_reg == IRQ_EN_OFF && wstrb_reg[0])
				irq_en_reg <= wdata_reg[IRQ_W-1:0];
		end
	end

	assign irq_clr = (do_write && awaddr_reg == IRQ_CLR_OFF && wstrb_reg[0]) ? wdata_reg[IRQ_W-1:0] : '0;

	// Set wins over a clear in the same cycle
	always_ff @(posedge clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			irq_stat_reg <= '0;
			irq_o        <= 1'b0;
		end
		else
		begin
			irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_set;
			irq_o        <= |(((irq_stat_reg & ~irq_clr) | irq_set) & irq_en_reg);
		end
	end

	always_comb
	begin
		rd_ok  = 1'b1;
		rd_val = 32'h0000_0000;
		case (s_axi_araddr_i)
			CTRL_OFF:     rd_val = ctrl_reg;
			STATUS_OFF:   rd_val = {26'h0, state_reg[1], state_reg[0], present};
			IRQ_STAT_OFF: rd_val = {28'h0, irq_stat_reg};
			IRQ_EN_OFF:   rd_val = {28'h0, irq_en_reg};
			IRQ_CLR_OFF:  rd_val = 32'h0000_0000;
			SOCK_A_OFF:   rd_val = sock_a_reg;
			SOCK_B_OFF:   rd_val = sock_b_reg;
			default:      rd_ok = 1'b0;
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s_axi_arready_o <= 1'b0;
			s_axi_rvalid_o  <= 1'b0;
			s_axi_rdata_o   <= 32'h0000_0000;
			s_axi_rresp_o   <= RESP_OKAY;
		end
		else
		begin
			s_axi_arready_o <= !s_axi_rvalid_o && !s_axi_arready_o;
			if (s_axi_arvalid_i && s_axi_arready_o)
			begin
				s_axi_arready_o <= 1'b0;
				s_axi_rvalid_o  <= 1'b1;
				s_axi_rdata_o   <= rd_val;
				s_axi_rresp_o   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
			end
			else if (s_axi_rvalid_o && s_axi_rready_i)
				s_axi_rvalid_o <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Switch control word encoding
	logic [CTRL_BITS-1:0] ctrl_word;
	logic [2:0]           vpp_a;
	logic [2:0]           vpp_b;
	logic [1:0]           vcc_a;
	logic [1:0]           vcc_b;

	// Unpowered sockets are commanded to 0 V; 1.8 V core code 111 only exists on type 0,
	// on type 1 it falls into the floating 11x group
	always_comb
	begin
		vpp_a = (state_reg[0] == SOCK_PRESENT_ON) ? sock_a_reg[2:0] : 3'h0;
		vcc_a = (state_reg[0] == SOCK_PRESENT_ON) ? sock_a_reg[4:3] : 2'h0;
		vpp_b = (state_reg[1] == SOCK_PRESENT_ON) ? sock_b_reg[2:0] : 3'h0;
		vcc_b = (state_reg[1] == SOCK_PRESENT_ON) ? sock_b_reg[4:3] : 2'h0;
		ctrl_word     = '0;
		ctrl_word[0]  = vpp_a[2];
		ctrl_word[1]  = vpp_a[1];
		ctrl_word[9]  = vpp_a[0];
		ctrl_word[3]  = vcc_a[1];
		ctrl_word[2]  = vcc_a[0];
		ctrl_word[4]  = vpp_b[2];
		ctrl_word[5]  = vpp_b[1];
		ctrl_word[10] = vpp_b[0];
		ctrl_word[6]  = vcc_b[1];
		ctrl_word[7]  = vcc_b[0];
		ctrl_word[8]  = ctrl_reg[CTRL_SHUTDOWN_BIT];
	end

	////////////////////////////////////////////////////////////////////////
	// Three-pin serial shifter, paced by the 16 kHz tick
	logic [CTRL_BITS-1:0] shift_reg;
	logic [3:0]           bit_cnt_reg;
	logic                 busy_reg;
	logic                 phase_reg;

	always_ff @(posedge clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			shift_reg   <= '0;
			bit_cnt_reg <= 4'h0;
			busy_reg    <= 1'b0;
			phase_reg   <= 1'b0;
			sw_clock_o  <= 1'b0;
			sw_data_o   <= 1'b0;
			sw_latch_o  <= 1'b0;
		end
		else if (osc_tick)
		begin
			sw_latch_o <= 1'b0;
			if (!busy_reg)
			begin
				shift_reg   <= ctrl_word;
				busy_reg    <= 1'b1;
				bit_cnt_reg <= 4'h0;
				phase_reg   <= 1'b0;
			end
			else if (!phase_reg)
			begin
				sw_data_o  <= shift_reg[CTRL_BITS-1];
				sw_clock_o <= 1'b0;
				phase_reg  <= 1'b1;
			end
			else
			begin
				sw_clock_o <= 1'b1;
				shift_reg  <= {shift_reg[CTRL_BITS-2:0], 1'b0};
				phase_reg  <= 1'b0;
				if (bit_cnt_reg == 4'(CTRL_BITS - 1))
				begin
					busy_reg   <= 1'b0;
					sw_latch_o <= 1'b1;
				end
				bit_cnt_reg <= bit_cnt_reg + 4'h1;
			end
		end
		else if (sw_clock_o && !phase_reg)
			sw_clock_o <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// Status-change pull selection and low-voltage card flags
	always_ff @(posedge clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			status_change_pullup_o   <= 1'b0;
			status_change_pulldown_o <= 1'b0;
			low_volt_card_flag_o     <= 1'b0;
			xx_volt_card_flag_o      <= 1'b0;
		end
		else
		begin
			status_change_pullup_o   <= present[0] && !sock_a_reg[SOCK_CB_BIT];
			status_change_pulldown_o <= present[0] && sock_a_reg[SOCK_CB_BIT];
			low_volt_card_flag_o     <= present[0] && sock_a_reg[SOCK_CB_BIT] &&
				sock_a_reg[SOCK_LV_BIT] && !swsel;
			xx_volt_card_flag_o      <= present[0] && sock_a_reg[SOCK_CB_BIT] &&
				sock_a_reg[SOCK_LV_BIT] && swsel;
		end
	end
endmodule

// >>> src/sock_pwr_pkg.sv
// Shared constants for socket detect and power switch control
package sock_pwr_pkg;
	localparam int unsigned CLK_HZ            = 40000000;
	localparam int unsigned DEBOUNCE_MS       = 50;
	localparam int unsigned DEBOUNCE_CYCLES   = CLK_HZ / 1000 * DEBOUNCE_MS;
	localparam int unsigned OSC_HZ            = 16000;
	localparam int unsigned OSC_HALF_CYCLES   = CLK_HZ / (2 * OSC_HZ);
	localparam int unsigned CTRL_BITS         = 11;
	// Register byte offsets
	localparam logic [7:0] CTRL_OFF           = 8'h00;
	localparam logic [7:0] STATUS_OFF         = 8'h04;
	localparam logic [7:0] IRQ_STAT_OFF       = 8'h08;
	localparam logic [7:0] IRQ_EN_OFF         = 8'h0c;
	localparam logic [7:0] IRQ_CLR_OFF        = 8'h10;
	localparam logic [7:0] SOCK_A_OFF         = 8'h14;
	localparam logic [7:0] SOCK_B_OFF         = 8'h18;
	// Control register fields
	localparam int unsigned CTRL_SWSEL_BIT    = 10;
	localparam int unsigned CTRL_SHUTDOWN_BIT = 0;
	localparam int unsigned CTRL_PWR_A_BIT    = 1;
	localparam int unsigned CTRL_PWR_B_BIT    = 2;
	localparam logic [31:0] CTRL_RESET        = 32'h0000_0001;
	// Socket request field: [2:0] programming code, [4:3] supply code, [5] card is CardBus,
	// [6] 1.8 V core card
	localparam logic [31:0] SOCK_RESET        = 32'h0000_0000;
	localparam int unsigned SOCK_CB_BIT       = 5;
	localparam int unsigned SOCK_LV_BIT       = 6;
	// Interrupt status bits
	localparam int unsigned IRQ_INS_A         = 0;
	localparam int unsigned IRQ_REM_A         = 1;
	localparam int unsigned IRQ_INS_B         = 2;
	localparam int unsigned IRQ_REM_B         = 3;
	localparam int unsigned IRQ_W             = 4;
	localparam logic [1:0] RESP_OKAY          = 2'b00;
	localparam logic [1:0] RESP_SLVERR        = 2'b10;
	typedef enum logic [1:0] {SOCK_EMPTY, SOCK_PRESENT_OFF, SOCK_PRESENT_ON} sock_state_t;
endpackage

// >>> verif/sock_pwr_props.sv
// Port-level assertions for the socket detect and power switch block
`timescale 1ns/1ps
module sock_pwr_props
#(
	parameter int unsigned OSC_HALF = 4
)(
	input wire logic        clk_i,
	input wire logic        rst_n_i,
	input wire logic        s_axi_awvalid_i,
	input wire logic        s_axi_awready_o,
	input wire logic        s_axi_arvalid_i,
	input wire logic        s_axi_arready_o,
	input wire logic        s_axi_bvalid_o,
	input wire logic        s_axi_rvalid_o,
	input wire logic        s_axi_rready_i,
	input wire logic        sw_clock_o,
	input wire logic        sw_data_o,
	input wire logic        sw_latch_o,
	input wire logic        status_change_pullup_o,
	input wire logic        status_change_pulldown_o,
	input wire logic        low_volt_card_flag_o,
	input wire logic        xx_volt_card_flag_o
);
	logic [15:0] latch_len_reg;
	logic [15:0] clock_len_reg;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	////////////////////////////////////////////////////////////////////////////////
	// High-phase lengths, judged on the falling edge since the tick is a parameter
	always_ff @(posedge clk_i or negedge rst_n_i)
		if (!rst_n_i)
			latch_len_reg <= 16'h0;
		else
			latch_len_reg <= sw_latch_o ? latch_len_reg + 16'h1 : 16'h0;
	always_ff @(posedge clk_i or negedge rst_n_i)
		if (!rst_n_i)
			clock_len_reg <= 16'h0;
		else
			clock_len_reg <= sw_clock_o ? clock_len_reg + 16'h1 : 16'h0;
	////////////////////////////////////////////////////////////////////////////////
	rd_answer_a: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
		else $error("read data late");
	rd_done_a: assert property (s_axi_rvalid_o && s_axi_rready_i |=> !s_axi_rvalid_o)
		else $error("read data repeated");
	wr_answer_a: assert property (s_axi_awvalid_i && s_axi_awready_o |-> ##[1:4] s_axi_bvalid_o)
		else $error("write response missing");
	latch_len_a: assert property ($fell(sw_latch_o) |-> latch_len_reg == 2 * OSC_HALF)
		else $error("latch pulse length wrong");
	latch_clock_a: assert property ($rose(sw_latch_o) |-> $rose(sw_clock_o))
		else $error("latch not on last clock rise");
	// Link clock is a one-cycle pulse at each tick that shifts a bit
	clock_len_a: assert property ($fell(sw_clock_o) |-> clock_len_reg == 16'h1)
		else $error("link clock high phase wrong");
	data_stable_a: assert property (sw_clock_o |-> $stable(sw_data_o))
		else $error("link data moved while clock high");
	pull_excl_a: assert property (!(status_change_pullup_o && status_change_pulldown_o))
		else $error("pullup and pulldown together");
	flag_excl_a: assert property (!(low_volt_card_flag_o && xx_volt_card_flag_o))
		else $error("both voltage flags set");
endmodule
bind socket_detect_power_switch_ctrl sock_pwr_props #(.OSC_HALF(OSC_HALF)) i_props (.*);

// >>> verif/switch_model.sv
// Behavioural external power switch capturing each latched control word
`timescale 1ns/1ps
module switch_model
(
	input  wire logic        clk_i,
	input  wire logic        sw_clock_i,
	input  wire logic        sw_data_i,
	input  wire logic        sw_latch_i,
	output logic [10:0]      word_o,
	output logic [15:0]      frames_o
);
	logic [10:0] shift_reg;
	logic [10:0] shift_next;
	logic        clock_reg;
	logic        latch_reg;
	initial
	begin
		shift_reg = 11'h0;
		word_o = 11'h0;
		frames_o = 16'h0;
		clock_reg = 1'b0;
		latch_reg = 1'b0;
	end
	// Last shift and latch share a tick, so the latch takes the shifted value
	always @(posedge clk_i)
	begin
		shift_next = (sw_clock_i && !clock_reg) ? {shift_reg[9:0], sw_data_i} : shift_reg;
		shift_reg <= shift_next;
		if (sw_latch_i && !latch_reg)
		begin
			word_o <= shift_next;
			frames_o <= frames_o + 16'h1;
		end
		clock_reg <= sw_clock_i;
		latch_reg <= sw_latch_i;
	end
endmodule

// >>> verif/test_socket_detect_power_switch_ctrl.sv
// Self-checking bench for the socket detect and power switch block
`timescale 1ns/1ps
module test_socket_detect_power_switch_ctrl
	import sock_pwr_pkg::*;
;
	logic clk_i, rst_n_i, sdmmc_detect_n_i, flash2_detect_n_i;
	logic [7:0] s_axi_awaddr_i, s_axi_araddr_i;
	logic [31:0] s_axi_wdata_i, s_axi_rdata_o;
	logic [3:0] s_axi_wstrb_i;
	logic s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i, s_axi_rready_i;
	logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
	logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
	logic sw_clock_o, sw_data_o, sw_latch_o, status_change_pullup_o, status_change_pulldown_o;
	logic low_volt_card_flag_o, xx_volt_card_flag_o, irq_o;
	logic [10:0] word;
	logic [15:0] frames;
	int error_cnt = 0;
	int compares = 0;
	socket_detect_power_switch_ctrl #(.DEBOUNCE_CNT(20), .OSC_HALF(4)) i_dut (.*);
	switch_model i_switch (.clk_i(clk_i), .sw_clock_i(sw_clock_o), .sw_data_i(sw_data_o),
		.sw_latch_i(sw_latch_o), .word_o(word), .frames_o(frames));
	initial
	begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e)
		begin
			error_cnt++;
			$display("ERROR t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic complete_run();
		$display("Counts: compares=%0d errors=%0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic hang();
		chk(32'h0, 32'h1);
		complete_run();
	endtask
	// Readies are registered, so the negedge value is what the next edge samples
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		logic ta;
		logic tw;
		@(posedge clk_i);
		s_axi_awaddr_i <= a;
		s_axi_wdata_i <= d;
		s_axi_awvalid_i <= 1'b1;
		s_axi_wvalid_i <= 1'b1;
		s_axi_bready_i <= 1'b1;
		for (n = 0; n < 60; n++)
		begin
			@(negedge clk_i);
			if (s_axi_bvalid_o === 1'b1)
				break;
			ta = s_axi_awvalid_i && s_axi_awready_o === 1'b1;
			tw = s_axi_wvalid_i && s_axi_wready_o === 1'b1;
			@(posedge clk_i);
			if (ta)
				s_axi_awvalid_i <= 1'b0;
			if (tw)
				s_axi_wvalid_i <= 1'b0;
		end
		if (n == 60)
			hang();
		chk(s_axi_bresp_o, er);
		@(posedge clk_i);
		s_axi_bready_i <= 1'b0;
	endtask
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		logic ta;
		@(posedge clk_i);
		s_axi_araddr_i <= a;
		s_axi_arvalid_i <= 1'b1;
		s_axi_rready_i <= 1'b1;
		for (n = 0; n < 60; n++)
		begin
			@(negedge clk_i);
			if (s_axi_rvalid_o === 1'b1)
				break;
			ta = s_axi_arvalid_i && s_axi_arready_o === 1'b1;
			@(posedge clk_i);
			if (ta)
				s_axi_arvalid_i <= 1'b0;
		end
		if (n == 60)
			hang();
		d = s_axi_rdata_o;
		r = s_axi_rresp_o;
		@(posedge clk_i);
		s_axi_rready_i <= 1'b0;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0] r;
		axi_rd(a, d, r);
		chk(d & m, e);
	endtask
	// Waits for two latched words so the second holds the current settings
	task automatic wait_frame();
		logic [15:0] f;
		int n;
		f = frames;
		for (n = 0; n < 1000 && frames < f + 16'h2; n++)
			@(posedge clk_i);
		if (n == 1000)
			hang();
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		logic [31:0] d;
		logic [1:0] r;
		rd_chk(CTRL_OFF, 32'hffffffff, CTRL_RESET);
		rd_chk(STATUS_OFF, 32'h3f, 32'h0);
		rd_chk(SOCK_A_OFF, 32'hffffffff, SOCK_RESET);
		axi_rd(8'h1c, d, r);
		chk(r, RESP_SLVERR);
		axi_wr(STATUS_OFF, 32'h0, RESP_SLVERR);
		rd_chk(IRQ_CLR_OFF, 32'hffffffff, 32'h0);
		wait_frame();
		chk(word, 32'h100);
		$display("t_reset done");
	endtask
	task automatic t_sock_a();
		axi_wr(IRQ_EN_OFF, 32'h1, RESP_OKAY);
		axi_wr(SOCK_A_OFF, 32'h6f, RESP_OKAY);
		@(posedge clk_i);
		sdmmc_detect_n_i <= 1'b0;
		repeat (15) @(posedge clk_i);
		sdmmc_detect_n_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		sdmmc_detect_n_i <= 1'b0;
		repeat (10) @(posedge clk_i);
		rd_chk(STATUS_OFF, 32'h1, 32'h0);
		repeat (30) @(posedge clk_i);
		rd_chk(STATUS_OFF, 32'hf, 32'h5);
		chk(irq_o, 1'b1);
		rd_chk(IRQ_STAT_OFF, 32'hf, 32'h1);
		chk({status_change_pullup_o, status_change_pulldown_o}, 2'b01);
		chk({low_volt_card_flag_o, xx_volt_card_flag_o}, 2'b10);
		axi_wr(IRQ_CLR_OFF, 32'h1, RESP_OKAY);
		repeat (3) @(posedge clk_i);
		chk(irq_o, 1'b0);
		axi_wr(CTRL_OFF, 32'h3, RESP_OKAY);
		repeat (20) @(posedge clk_i);
		rd_chk(STATUS_OFF, 32'hf, 32'h9);
		wait_frame();
		chk(word, 32'h307);
		axi_wr(CTRL_OFF, 32'h403, RESP_OKAY);
		repeat (4) @(posedge clk_i);
		chk({low_volt_card_flag_o, xx_volt_card_flag_o}, 2'b01);
		axi_wr(SOCK_A_OFF, 32'h0f, RESP_OKAY);
		repeat (4) @(posedge clk_i);
		chk({status_change_pullup_o, status_change_pulldown_o}, 2'b10);
		sdmmc_detect_n_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		rd_chk(STATUS_OFF, 32'hf, 32'h0);
		rd_chk(IRQ_STAT_OFF, 32'h2, 32'h2);
		chk(irq_o, 1'b0);
		wait_frame();
		chk(word, 32'h100);
		$display("t_sock_a done");
	endtask
	task automatic t_sock_b();
		axi_wr(IRQ_EN_OFF, 32'h4, RESP_OKAY);
		axi_wr(SOCK_B_OFF, 32'h14, RESP_OKAY);
		@(posedge clk_i);
		flash2_detect_n_i <= 1'b0;
		repeat (40) @(posedge clk_i);
		rd_chk(STATUS_OFF, 32'h32, 32'h12);
		chk(irq_o, 1'b1);
		axi_wr(CTRL_OFF, 32'h405, RESP_OKAY);
		repeat (20) @(posedge clk_i);
		rd_chk(STATUS_OFF, 32'h32, 32'h22);
		wait_frame();
		chk(word, 32'h150);
		axi_wr(CTRL_OFF, 32'h404, RESP_OKAY);
		wait_frame();
		chk(word, 32'h050);
		@(posedge clk_i);
		flash2_detect_n_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		rd_chk(STATUS_OFF, 32'h32, 32'h0);
		rd_chk(IRQ_STAT_OFF, 32'h8, 32'h8);
		axi_wr(IRQ_CLR_OFF, 32'hf, RESP_OKAY);
		rd_chk(IRQ_STAT_OFF, 32'hf, 32'h0);
		chk(irq_o, 1'b0);
		$display("t_sock_b done");
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		rst_n_i = 1'b0;
		sdmmc_detect_n_i = 1'b1;
		flash2_detect_n_i = 1'b1;
		s_axi_awaddr_i = 8'h0;
		s_axi_araddr_i = 8'h0;
		s_axi_wdata_i = 32'h0;
		s_axi_wstrb_i = 4'hf;
		{s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i, s_axi_rready_i} = 5'h0;
		repeat (4) @(posedge clk_i);
		rst_n_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		t_reset();
		t_sock_a();
		t_sock_b();
		complete_run();
	end
endmodule
